// file: hw/ppol_pin_cell.sv
// One port pin: override muxing, input gate, synchroniser and edge detect
`timescale 1ns/1ps
`default_nettype none
module ppol_pin_cell (
   input  wire logic                clock_in,
   input  wire logic                reset_in,
   input  wire ppol_pkg::ppol_ovr_t ovr_in,
   input  wire logic                drive_select_bit_in,
   input  wire logic                output_latch_bit_in,
   input  wire logic                global_pullup_off_in,
   input  wire logic                clamp_in,
   input  wire logic                ext_req_en_in,
   input  wire logic [1:0]          sense_in,
   input  wire logic                pad_in,
   output var  logic                pullup_en_out,
   output var  logic                pad_out,
   output var  logic                pad_oe_n_out,
   output var  logic                gated_out,
   output var  logic                pin_sample_bit_out,
   output var  logic                event_out
);

   logic input_enable;
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic prev_q;

   // ----------------------------------------------------------------
   // Input gate and clamp
   // ----------------------------------------------------------------
   always_comb begin
      if (ovr_in.input_gate_override_enable) begin
         input_enable = ovr_in.input_gate_override_value;
      end else begin
         input_enable = !(clamp_in && !ext_req_en_in);
      end
      gated_out = pad_in & input_enable;
   end

   // ----------------------------------------------------------------
   // Pad driver, pull-up
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         pullup_en_out <= 1'b0;
         pad_oe_n_out  <= 1'b1;
         pad_out       <= 1'b0;
      end else begin
         if (ovr_in.pullup_override_enable) begin
            pullup_en_out <= ovr_in.pullup_override_value;
         end else begin
            pullup_en_out <= !drive_select_bit_in && output_latch_bit_in && !global_pullup_off_in;
         end
         if (ovr_in.drive_override_enable) begin
            pad_oe_n_out <= !ovr_in.drive_override_value;
         end else begin
            pad_oe_n_out <= !drive_select_bit_in;
         end
         pad_out <= ovr_in.level_override_enable ? ovr_in.level_override_value : output_latch_bit_in;
      end
   end

   // ----------------------------------------------------------------
   // Synchroniser on the gated input
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         sync1_q            <= 1'b0;
         sync2_q            <= 1'b0;
         sync3_q            <= 1'b0;
         pin_sample_bit_out <= 1'b0;
         prev_q             <= 1'b0;
      end else begin
         sync1_q <= gated_out;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q) begin
            pin_sample_bit_out <= sync3_q;
         end
         prev_q <= pin_sample_bit_out;
      end
   end

   // Clamp release looks like a real edge, so a held-high rise- or any-sensing pin flags on wake
   always_comb begin
      case (sense_in)
         ppol_pkg::SENSE_ANY:  event_out = pin_sample_bit_out != prev_q;
         ppol_pkg::SENSE_FALL: event_out = !pin_sample_bit_out && prev_q;
         ppol_pkg::SENSE_RISE: event_out = pin_sample_bit_out && !prev_q;
         default:              event_out = 1'b0;
      endcase
   end

endmodule : ppol_pin_cell
`default_nettype wire

// file: hw/ppol_port.sv
// Port with alternate-function overrides, sleep input clamp and AXI4-Lite registers
// Notes on behaviour
// - In a clamping sleep, a pin's input path is forced low unless overridden.
// - The clamp is requested only in power-down, standby and ADC noise reduction.
// - A pin whose external interrupt request is enabled is not clamped.
// - A held-high rise- or any-sensing pin with its request disabled flags on wake.
// - Pull-up follows its override value when overridden, else dir/latch/off = 0/1/0.
// - Driver enable follows its override value when overridden, else the direction bit.
// - Pin level follows the level override when enabled, else the output latch.
// - The input gate override value wins over the sleep state when enabled.
// - The alternate-function input is taken after the gate, before the synchroniser.
// - The analog link is wired straight to the pad.
// - Override signals come from the owning peripheral, not from port registers.
// - All pull-ups are off while reset is active.
// - Direction bit one makes an output, zero an input.
// - The global pull-up-off bit disables every non-overridden pull-up.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppol_port #(
   parameter int unsigned NUM_PINS = 8,
   parameter int unsigned ADDR_W   = 8
) (
   input  wire logic                               clock_in,
   input  wire logic                               reset_in,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]                  s_axi_awaddr_in,
   input  wire logic                               s_axi_awvalid_in,
   output var  logic                               s_axi_awready_out,
   input  wire logic [31:0]                        s_axi_wdata_in,
   input  wire logic [3:0]                         s_axi_wstrb_in,
   input  wire logic                               s_axi_wvalid_in,
   output var  logic                               s_axi_wready_out,
   output var  logic [1:0]                         s_axi_bresp_out,
   output var  logic                               s_axi_bvalid_out,
   input  wire logic                               s_axi_bready_in,
   input  wire logic [ADDR_W-1:0]                  s_axi_araddr_in,
   input  wire logic                               s_axi_arvalid_in,
   output var  logic                               s_axi_arready_out,
   output var  logic [31:0]                        s_axi_rdata_out,
   output var  logic [1:0]                         s_axi_rresp_out,
   output var  logic                               s_axi_rvalid_out,
   input  wire logic                               s_axi_rready_in,
   // Sleep controller and peripherals
   input  wire ppol_pkg::ppol_sleep_t              sleep_mode_in,
   input  wire ppol_pkg::ppol_ovr_t [NUM_PINS-1:0] override_in,
   output var  logic                               irq_out,
   // Pads
   input  wire logic [NUM_PINS-1:0]                pad_in,
   output var  logic [NUM_PINS-1:0]                pad_out,
   output var  logic [NUM_PINS-1:0]                pad_oe_n_out,
   output var  logic [NUM_PINS-1:0]                pullup_en_out,
   output var  logic [NUM_PINS-1:0]                alt_func_input_tap_out,
   output var  logic [NUM_PINS-1:0]                analog_pad_link_out
);

   localparam logic [31:0] PIN_MASK   = 32'((64'h1 << NUM_PINS) - 64'h1);
   localparam logic [31:0] SENSE_MASK = 32'((64'h1 << (2 * NUM_PINS)) - 64'h1);

   logic [ADDR_W-1:0]   awaddr_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                wr_fire;
   logic                wr_hit;
   logic                rd_take;
   logic                rd_hit;
   logic [31:0]         rd_data;
   logic [31:0]         dir_q;
   logic [31:0]         latch_q;
   logic [31:0]         ctrl_q;
   logic [31:0]         sense_q;
   logic [31:0]         status_q;
   logic [31:0]         status_d;
   logic [31:0]         mask_q;
   logic                clamp_q;
   logic [NUM_PINS-1:0] gated_w;
   logic [NUM_PINS-1:0] sample_w;
   logic [NUM_PINS-1:0] event_w;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign wr_fire = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;

   always_comb begin
      case (awaddr_q)
         ADDR_W'(ppol_pkg::OFF_DIR),
         ADDR_W'(ppol_pkg::OFF_LATCH),
         ADDR_W'(ppol_pkg::OFF_PIN),
         ADDR_W'(ppol_pkg::OFF_CTRL),
         ADDR_W'(ppol_pkg::OFF_SENSE),
         ADDR_W'(ppol_pkg::OFF_STATUS),
         ADDR_W'(ppol_pkg::OFF_MASK): wr_hit = 1'b1;
         default:                     wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out  <= 1'b1;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= ppol_pkg::RESP_OKAY;
         awaddr_q          <= '0;
         wdata_q           <= ppol_pkg::REG_RESET;
         wstrb_q           <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            s_axi_awready_out <= 1'b0;
            awaddr_q          <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            s_axi_wready_out <= 1'b0;
            wdata_q          <= s_axi_wdata_in;
            wstrb_q          <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_hit ? ppol_pkg::RESP_OKAY : ppol_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out  <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software-written registers
   // ----------------------------------------------------------------
   // Overrides never touch these; they arrive only on override_in
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         dir_q   <= ppol_pkg::REG_RESET;
         latch_q <= ppol_pkg::REG_RESET;
         ctrl_q  <= ppol_pkg::REG_RESET;
         sense_q <= ppol_pkg::REG_RESET;
         mask_q  <= ppol_pkg::REG_RESET;
      end else if (wr_fire) begin
         case (awaddr_q)
            ADDR_W'(ppol_pkg::OFF_DIR):
               dir_q <= ppol_pkg::ppol_merge(dir_q, wdata_q, wstrb_q) & PIN_MASK;
            ADDR_W'(ppol_pkg::OFF_LATCH):
               latch_q <= ppol_pkg::ppol_merge(latch_q, wdata_q, wstrb_q) & PIN_MASK;
            ADDR_W'(ppol_pkg::OFF_CTRL):
               ctrl_q <= ppol_pkg::ppol_merge(ctrl_q, wdata_q, wstrb_q) & (32'h0000_0001 << ppol_pkg::CTRL_PULLUP_OFF_BIT);
            ADDR_W'(ppol_pkg::OFF_SENSE):
               sense_q <= ppol_pkg::ppol_merge(sense_q, wdata_q, wstrb_q) & SENSE_MASK;
            ADDR_W'(ppol_pkg::OFF_MASK):
               mask_q <= ppol_pkg::ppol_merge(mask_q, wdata_q, wstrb_q) & PIN_MASK;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign rd_take = s_axi_arvalid_in && s_axi_arready_out;

   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      case (s_axi_araddr_in)
         ADDR_W'(ppol_pkg::OFF_DIR):    rd_data = dir_q;
         ADDR_W'(ppol_pkg::OFF_LATCH):  rd_data = latch_q;
         ADDR_W'(ppol_pkg::OFF_PIN):    rd_data = 32'(sample_w);
         ADDR_W'(ppol_pkg::OFF_CTRL):   rd_data = ctrl_q;
         ADDR_W'(ppol_pkg::OFF_SENSE):  rd_data = sense_q;
         ADDR_W'(ppol_pkg::OFF_STATUS): rd_data = status_q;
         ADDR_W'(ppol_pkg::OFF_MASK):   rd_data = mask_q;
         default:                       rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= ppol_pkg::RESP_OKAY;
      end else begin
         if (rd_take) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_data;
            s_axi_rresp_out   <= rd_hit ? ppol_pkg::RESP_OKAY : ppol_pkg::RESP_SLVERR;
         end
         if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flags: read clears, a same-cycle event still lands
   // ----------------------------------------------------------------
   always_comb begin
      status_d = status_q;
      if (rd_take && s_axi_araddr_in == ADDR_W'(ppol_pkg::OFF_STATUS)) begin
         status_d = 32'h0000_0000;
      end
      status_d = status_d | 32'(event_w);
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         status_q <= ppol_pkg::REG_RESET;
         irq_out  <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_out  <= |(status_d & mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Sleep clamp request
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         clamp_q <= 1'b0;
      end else begin
         case (sleep_mode_in)
            ppol_pkg::PPOL_POWER_DOWN,
            ppol_pkg::PPOL_STANDBY,
            ppol_pkg::PPOL_ADC_NR: clamp_q <= 1'b1;
            default:               clamp_q <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      ppol_pin_cell u_cell (
         .clock_in             (clock_in),
         .reset_in             (reset_in),
         .ovr_in               (override_in[g]),
         .drive_select_bit_in  (dir_q[g]),
         .output_latch_bit_in  (latch_q[g]),
         .global_pullup_off_in (ctrl_q[ppol_pkg::CTRL_PULLUP_OFF_BIT]),
         .clamp_in             (clamp_q),
         .ext_req_en_in        (mask_q[g]),
         .sense_in             (sense_q[2*g +: 2]),
         .pad_in               (pad_in[g]),
         .pullup_en_out        (pullup_en_out[g]),
         .pad_out              (pad_out[g]),
         .pad_oe_n_out         (pad_oe_n_out[g]),
         .gated_out            (gated_w[g]),
         .pin_sample_bit_out   (sample_w[g]),
         .event_out            (event_w[g])
      );
   end

   // Unsynchronised by design; consumers must synchronise unless clocking on it
   assign alt_func_input_tap_out = gated_w;
   // Passive wire; the pad level is resolved outside
   assign analog_pad_link_out    = pad_in;

   // ----------------------------------------------------------------
   // Assertions (pin 0 with its level override; pull-up, drive and gate overrides on pins 2 and 3, where peripherals use them)
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);

   property p_clamp_low;
      clamp_q && !mask_q[0] && !override_in[0].input_gate_override_enable |-> !gated_w[0];
   endproperty
   a_clamp_low: assert property (p_clamp_low) else $error("clamped pin not low");

   property p_clamp_modes;
      (sleep_mode_in == ppol_pkg::PPOL_ACTIVE || sleep_mode_in == ppol_pkg::PPOL_IDLE) |=> !clamp_q;
   endproperty
   a_clamp_modes: assert property (p_clamp_modes) else $error("clamp outside deep sleep");

   property p_req_bypass;
      mask_q[0] && !override_in[0].input_gate_override_enable |-> gated_w[0] == pad_in[0];
   endproperty
   a_req_bypass: assert property (p_req_bypass) else $error("enabled request pin clamped");

   property p_rise_flag;
      sense_q[1:0] == ppol_pkg::SENSE_RISE && $rose(sample_w[0]) |=> status_q[0];
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rising edge lost flag");

   property p_pullup_ovr;
      override_in[2].pullup_override_enable |=>
         pullup_en_out[2] == $past(override_in[2].pullup_override_value);
   endproperty
   a_pullup_ovr: assert property (p_pullup_ovr) else $error("pull-up override ignored");

   property p_drive_ovr;
      override_in[2].drive_override_enable |=>
         pad_oe_n_out[2] == !$past(override_in[2].drive_override_value);
   endproperty
   a_drive_ovr: assert property (p_drive_ovr) else $error("drive override ignored");

   property p_level;
      1'b1 |=> pad_out[0] == ($past(override_in[0].level_override_enable) ?
                              $past(override_in[0].level_override_value) : $past(latch_q[0]));
   endproperty
   a_level: assert property (p_level) else $error("pin level wrong");

   property p_gate_ovr;
      override_in[3].input_gate_override_enable |->
         gated_w[3] == (pad_in[3] && override_in[3].input_gate_override_value);
   endproperty
   a_gate_ovr: assert property (p_gate_ovr) else $error("input gate override ignored");

   property p_reset_off;
      @(posedge clock_in) disable iff (1'b0) reset_in |=> !pullup_en_out[0] && pad_oe_n_out[0];
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("pull-up or driver on in reset");

   property p_dir;
      !override_in[0].drive_override_enable |=> pad_oe_n_out[0] == !$past(dir_q[0]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction bit ignored");

   property p_pud;
      ctrl_q[ppol_pkg::CTRL_PULLUP_OFF_BIT] && !override_in[0].pullup_override_enable |=> !pullup_en_out[0];
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up on with global off");

   property p_sample_gated;
      !gated_w[0] [*4] |=> !sample_w[0];
   endproperty
   a_sample_gated: assert property (p_sample_gated) else $error("sample not from gated input");

   c_clamp: cover property ($rose(clamp_q));
   c_flag: cover property ($rose(status_q[0]));
   c_irq: cover property ($rose(irq_out));

endmodule : ppol_port
`default_nettype wire

// file: pkg/ppol_pkg.sv
// Shared constants, types and helpers for the port pin override block
package ppol_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_DIR    = 8'h00;
   localparam logic [7:0] OFF_LATCH  = 8'h04;
   localparam logic [7:0] OFF_PIN    = 8'h08;
   localparam logic [7:0] OFF_CTRL   = 8'h0C;
   localparam logic [7:0] OFF_SENSE  = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_MASK   = 8'h18;

   // ----------------------------------------------------------------
   // Fields, reset values, answers
   // ----------------------------------------------------------------
   localparam int          CTRL_PULLUP_OFF_BIT = 6;
   localparam logic [31:0] REG_RESET           = 32'h0000_0000;
   localparam logic [1:0]  SENSE_NONE          = 2'h0;
   localparam logic [1:0]  SENSE_ANY           = 2'h1;
   localparam logic [1:0]  SENSE_FALL          = 2'h2;
   localparam logic [1:0]  SENSE_RISE          = 2'h3;
   localparam logic [1:0]  RESP_OKAY           = 2'h0;
   localparam logic [1:0]  RESP_SLVERR         = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      PPOL_ACTIVE     = 5'h01,
      PPOL_IDLE       = 5'h02,
      PPOL_ADC_NR     = 5'h04,
      PPOL_POWER_DOWN = 5'h08,
      PPOL_STANDBY    = 5'h10
   } ppol_sleep_t;

   typedef struct packed {
      logic pullup_override_enable;
      logic pullup_override_value;
      logic drive_override_enable;
      logic drive_override_value;
      logic level_override_enable;
      logic level_override_value;
      logic input_gate_override_enable;
      logic input_gate_override_value;
   } ppol_ovr_t;

   // Byte-lane merge for AXI write strobes
   function automatic logic [31:0] ppol_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : ppol_merge

endpackage : ppol_pkg

// file: verification/port_pin_override_logic_bench.sv
// Self-checking bench for the port pin override block
`timescale 1ns/1ps
`default_nettype none
module port_pin_override_logic_bench;
   logic        clock_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pad = 8'hFF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  mode = 2'h0, bresp, rresp, rs;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]  pad_out, oe_n, pu, tap, ana;
   int          fail_count = 0, num_checks = 0, cycles = 0;
   ppol_pkg::ppol_sleep_t     sleep = ppol_pkg::PPOL_ACTIVE;
   ppol_pkg::ppol_ovr_t [7:0] ovr;
   always #25 clock_in = ~clock_in;
   ppol_periph_model peri (.clock_in(clock_in), .reset_in(reset_in), .mode_in(mode), .override_out(ovr));
   ppol_port #(.NUM_PINS(8), .ADDR_W(8)) dut (.clock_in(clock_in), .reset_in(reset_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .sleep_mode_in(sleep), .override_in(ovr), .irq_out(irq), .pad_in(pad), .pad_out(pad_out),
      .pad_oe_n_out(oe_n), .pullup_en_out(pu), .alt_func_input_tap_out(tap), .analog_pad_link_out(ana));
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Address and data released independently, each on its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_o;
      logic w_o;
      aw_o = 1'b1;
      w_o = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock_in);
         aw_o = aw_o && !awready;
         w_o = w_o && !wready;
         awvalid <= aw_o;
         wvalid <= w_o;
      end while (aw_o || w_o);
      do @(posedge clock_in); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge clock_in);
   endtask : wr
   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock_in); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock_in); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clock_in);
   endtask : rdr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rdr(a, rd, rs);
      chk(rd, exp);
   endtask : rchk
   task automatic t_gpio;
      wr(ppol_pkg::OFF_LATCH, 32'hC3, rs);
      wr(ppol_pkg::OFF_DIR, 32'h2F, rs);
      repeat (2) @(posedge clock_in);
      chk(32'(pu), 32'hC0);
      chk(32'(oe_n), 32'hD0);
      chk(32'(pad_out & 8'h2F), 32'h03);
      mode <= 2'h1;
      repeat (3) @(posedge clock_in);
      chk(32'(pu), 32'h84);
      chk(32'(oe_n), 32'h70);
      chk(32'(pad_out & 8'h8F), 32'h87);
      wr(ppol_pkg::OFF_CTRL, 32'h40, rs);
      repeat (2) @(posedge clock_in);
      chk(32'(pu), 32'h04);
      mode <= 2'h0;
      repeat (3) @(posedge clock_in);
      chk(32'(pu), 32'h00);
      rchk(ppol_pkg::OFF_CTRL, 32'h40);
   endtask : t_gpio
   task automatic t_clamp;
      wr(ppol_pkg::OFF_DIR, 32'h0, rs);
      wr(ppol_pkg::OFF_MASK, 32'h02, rs);
      mode <= 2'h2;
      for (int i = 0; i < 5; i++) begin
         sleep <= ppol_pkg::ppol_sleep_t'(5'h01 << i);
         repeat (6) @(posedge clock_in);
         chk(32'(tap), (i >= 2) ? 32'h06 : 32'hF7);
         rchk(ppol_pkg::OFF_PIN, (i >= 2) ? 32'h06 : 32'hF7);
      end
      sleep <= ppol_pkg::PPOL_ACTIVE;
      mode <= 2'h0;
      repeat (3) @(posedge clock_in);
      pad <= 8'h5A;
      #1;
      chk(32'(tap), 32'h5A);
      chk(32'(ana), 32'h5A);
      @(posedge clock_in);
      pad <= 8'hFF;
   endtask : t_clamp
   task automatic t_wake;
      wr(ppol_pkg::OFF_MASK, 32'h0, rs);
      // Codes 0..3: none, any, fall, rise
      for (int i = 0; i < 4; i++) begin
         wr(ppol_pkg::OFF_SENSE, 32'(i), rs);
         rdr(ppol_pkg::OFF_STATUS, rd, rs);
         sleep <= ppol_pkg::PPOL_POWER_DOWN;
         repeat (8) @(posedge clock_in);
         sleep <= ppol_pkg::PPOL_ACTIVE;
         repeat (8) @(posedge clock_in);
         rchk(ppol_pkg::OFF_STATUS, 32'(i != 0));
      end
      pad <= 8'h00;
      repeat (6) @(posedge clock_in);
      pad <= 8'hFF;
      repeat (8) @(posedge clock_in);
      chk(32'(irq), 32'h0);
      wr(ppol_pkg::OFF_MASK, 32'h1, rs);
      repeat (2) @(posedge clock_in);
      chk(32'(irq), 32'h1);
      rchk(ppol_pkg::OFF_STATUS, 32'h1);
      repeat (2) @(posedge clock_in);
      chk(32'(irq), 32'h0);
   endtask : t_wake
   task automatic t_bus;
      wr(8'h40, 32'h1, rs);
      chk(32'(rs), 32'(ppol_pkg::RESP_SLVERR));
      rdr(8'h40, rd, rs);
      chk(32'(rs), 32'(ppol_pkg::RESP_SLVERR));
      wr(ppol_pkg::OFF_PIN, 32'h0, rs);
      chk(32'(rs), 32'(ppol_pkg::RESP_OKAY));
   endtask : t_bus
   // Pull-ups enabled by software must still drop during a mid-run reset
   task automatic t_reset;
      wr(ppol_pkg::OFF_CTRL, 32'h0, rs);
      repeat (2) @(posedge clock_in);
      chk(32'(pu), 32'hC3);
      reset_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      chk(32'(pu), 32'h0);
      chk(32'(oe_n), 32'hFF);
      reset_in <= 1'b0;
      @(posedge clock_in);
      rchk(ppol_pkg::OFF_LATCH, ppol_pkg::REG_RESET);
   endtask : t_reset
   initial begin
      repeat (8) @(posedge clock_in);
      chk(32'(pu), 32'h0);
      reset_in <= 1'b0;
      @(posedge clock_in);
      chk(32'(oe_n), 32'hFF);
      rchk(ppol_pkg::OFF_DIR, ppol_pkg::REG_RESET);
      t_gpio();
      t_clamp();
      t_wake();
      t_bus();
      t_reset();
      tally_and_finish();
   end
endmodule : port_pin_override_logic_bench
`default_nettype wire

// file: verification/ppol_periph_model.sv
// Peripheral override source facing the port
`timescale 1ns/1ps
`default_nettype none
module ppol_periph_model (
   input  wire logic                      clock_in,
   input  wire logic                      reset_in,
   input  wire logic [1:0]                mode_in,
   output var  ppol_pkg::ppol_ovr_t [7:0] override_out
);
   // Registered, like the owning module's own state
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         override_out <= '0;
      end else if (mode_in == 2'h1) begin
         override_out <= {8'h30, 8'h80, 8'h20, 16'h0000, 8'hFC, 16'h0000};
      end else if (mode_in == 2'h2) begin
         override_out <= {32'h0000_0000, 8'h02, 8'h03, 16'h0000};
      end else begin
         override_out <= '0;
      end
   end
endmodule : ppol_periph_model
`default_nettype wire
